// *** uicfs_cfg.svh ***
`ifndef UICFS_CFG_SVH
`define UICFS_CFG_SVH
// Summary of operation
// - fifo mode: rx data interrupt while rx fill at or above trigger level
// - data ready status set on character into rx fifo, cleared when empty
// - mask bits 0-3 clear with fifos on gives polled mode via line status
// - line status: data ready, head errors, thr empty, tx idle, any fifo error
// - non-fifo mode: rx data interrupt while holding register has a character
// - tx ready on thr empty or below trigger; enabling while empty fires
// - line status interrupt when a character arrives with status bits 1-4 set
// - modem status interrupt while any of the four delta bits is set
// - flow change interrupt on rising cts or rts during auto flow control
// - xoff interrupt on received xoff or special character when enabled
// - time-out interrupt when data waits and the delay timer expires
// - tx ready also on tx fifo empty, or only transmitter empty in rs485 mode with fifos on
// - identification read shows only highest pending source
// - identification codes: 06,0C,04,02,00,10,20, none 01
// - bit 0 is 1 with nothing pending, 0 when pending
// - tx ready cleared by identification read or holding register write
// - time-out clears on rx read, line on line read, modem on modem read
// - xoff clears on identification read or xon; special on read or next char (one shared flag here: either clears on read, xon or next char)
// - flow change interrupts clear only on modem status read
// - identification bits 7:6 read 11 with fifos on, 00 with fifos off
// - fifo control bit 0 enables fifos; other bits ignored unless bit 0 set
`define UICFS_OFS_MASK     8'h00
`define UICFS_OFS_IDENT    8'h04
`define UICFS_OFS_FIFOCTL  8'h08
`define UICFS_OFS_LSTAT    8'h0C
`define UICFS_OFS_CTRL     8'h10
`define UICFS_ID_LINE      6'h06
`define UICFS_ID_TIMEOUT   6'h0C
`define UICFS_ID_RXDATA    6'h04
`define UICFS_ID_TRANSMIT_READY_INTERRUPT     6'h02
`define UICFS_ID_MODEM     6'h00
`define UICFS_ID_XOFF      6'h10
`define UICFS_ID_FLOW      6'h20
`define UICFS_ID_NONE      6'h01
`define UICFS_MASK_RX      0
`define UICFS_MASK_TX      1
`define UICFS_MASK_LINE    2
`define UICFS_MASK_MODEM   3
`define UICFS_MASK_XOFF    5
`define UICFS_MASK_RTS     6
`define UICFS_MASK_CTS     7
`define UICFS_FIFO_EN      0
`define UICFS_RESET_BYTE   8'h00
`endif

// *** uicfs_pkg.sv ***
package uicfs_pkg;
  typedef enum logic [2:0] {
    uicfs_src_none, uicfs_src_line, uicfs_src_timeout, uicfs_src_rxdata,
    uicfs_src_transmit_ready_interrupt, uicfs_src_modem, uicfs_src_xoff, uicfs_src_flow
  } uicfs_src_t;
  typedef enum logic [1:0] {
    uicfs_bus_idle, uicfs_bus_answer
  } uicfs_bus_t;
endpackage

// *** uicfs_top.sv ***
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uicfs_cfg.svh"
module uicfs_top (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  input  wire logic        rx_char_stored,
  input  wire logic        rx_char_error,
  input  wire logic [3:0]  rx_head_status,
  input  wire logic        rx_fifo_any_error,
  input  wire logic        rx_fifo_empty,
  input  wire logic        rx_at_trigger,
  input  wire logic        rx_timeout_expired,
  input  wire logic        rx_holding_read,
  input  wire logic        tx_holding_empty,
  input  wire logic        tx_below_trigger,
  input  wire logic        tx_fifo_empty,
  input  wire logic        tx_all_empty,
  input  wire logic        tx_holding_write,
  input  wire logic        rs485_mode,
  input  wire logic [3:0]  modem_deltas,
  input  wire logic        modem_status_read,
  input  wire logic        enhanced_enable,
  input  wire logic        auto_cts,
  input  wire logic        auto_rts,
  input  wire logic        cts_pin,
  input  wire logic        rts_pin,
  input  wire logic        xoff_received,
  input  wire logic        xon_received,
  input  wire logic        special_received,
  output var  logic        irq,
  output var  logic        fifo_enable,
  output var  logic [7:0]  fifo_control_bits
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] cts_sync;
  logic [1:0] rts_sync;
  logic       cts_prev;
  logic       rts_prev;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cts_sync <= 2'h0;
      rts_sync <= 2'h0;
      cts_prev <= 1'b0;
      rts_prev <= 1'b0;
    end else begin
      cts_sync <= {cts_sync[0], cts_pin};
      rts_sync <= {rts_sync[0], rts_pin};
      cts_prev <= cts_sync[1];
      rts_prev <= rts_sync[1];
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]           interrupt_mask;
  logic                 ident_rd;
  logic                 lstat_rd;
  logic                 bus_take;
  uicfs_pkg::uicfs_bus_t bus_state;
  uicfs_pkg::uicfs_src_t src;

  // a request is taken on the first edge it is seen, answered the next
  assign bus_take = (read | write) && bus_state == uicfs_pkg::uicfs_bus_idle;
  assign ident_rd = bus_take && read && address == `UICFS_OFS_IDENT;
  assign lstat_rd = bus_take && read && address == `UICFS_OFS_LSTAT;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interrupt_mask <= `UICFS_RESET_BYTE;
    end else if (bus_take && write && address == `UICFS_OFS_MASK) begin
      // upper enables only reachable with enhanced functions on
      interrupt_mask[3:0] <= writedata[3:0];
      if (enhanced_enable) begin
        interrupt_mask[7:4] <= writedata[7:4];
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fifo_enable       <= 1'b0;
      fifo_control_bits <= `UICFS_RESET_BYTE;
    end else if (bus_take && write && address == `UICFS_OFS_FIFOCTL) begin
      fifo_enable <= writedata[`UICFS_FIFO_EN];
      if (writedata[`UICFS_FIFO_EN]) begin
        fifo_control_bits <= writedata[7:0];
      end else begin
        fifo_control_bits <= `UICFS_RESET_BYTE;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt sources
  // ------------------------------------------------------------
  logic line_pend;
  logic modem_pend;
  logic tx_pend;
  logic xoff_pend;
  logic cts_pend;
  logic rts_pend;
  logic timeout_pend;
  logic tx_event;
  logic tx_enable_rise;
  logic tx_event_prev;
  logic tx_event_rise;

  // tx ready events; in rs485 mode with fifos on wait for the whole transmitter
  assign tx_event = fifo_enable
      ? (rs485_mode ? tx_all_empty : (tx_below_trigger | tx_fifo_empty))
      : tx_holding_empty;
  assign tx_enable_rise = bus_take && write && address == `UICFS_OFS_MASK &&
      writedata[`UICFS_MASK_TX] && !interrupt_mask[`UICFS_MASK_TX] && tx_holding_empty;

  // edge, not level: a standing level would re-arm the flag right after each clearing read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_event_prev <= 1'b0;
    end else begin
      tx_event_prev <= tx_event;
    end
  end
  assign tx_event_rise = tx_event && !tx_event_prev;

  // set wins over clear in every sticky source below, except a tx event rise meeting a holding register write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      line_pend <= 1'b0;
    end else if (rx_char_stored && rx_char_error) begin
      line_pend <= 1'b1;
    end else if (lstat_rd) begin
      line_pend <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_pend <= 1'b0;
    end else if (tx_enable_rise || (tx_event_rise && !tx_holding_write)) begin
      tx_pend <= 1'b1;
    end else if ((ident_rd && src == uicfs_pkg::uicfs_src_transmit_ready_interrupt) || tx_holding_write) begin
      tx_pend <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timeout_pend <= 1'b0;
    end else if (rx_timeout_expired && !rx_fifo_empty) begin
      timeout_pend <= 1'b1;
    end else if (rx_holding_read) begin
      timeout_pend <= 1'b0;
    end
  end

  // special character clears on the next received character
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      xoff_pend <= 1'b0;
    end else if (xoff_received || special_received) begin
      xoff_pend <= 1'b1;
    end else if ((ident_rd && src == uicfs_pkg::uicfs_src_xoff) || xon_received
                 || rx_char_stored) begin
      xoff_pend <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cts_pend <= 1'b0;
      rts_pend <= 1'b0;
    end else begin
      if (auto_cts && cts_sync[1] && !cts_prev) begin
        cts_pend <= 1'b1;
      end else if (modem_status_read) begin
        cts_pend <= 1'b0;
      end
      if (auto_rts && rts_sync[1] && !rts_prev) begin
        rts_pend <= 1'b1;
      end else if (modem_status_read) begin
        rts_pend <= 1'b0;
      end
    end
  end

  // modem deltas are held by the modem status register and clear on its read
  assign modem_pend = |modem_deltas;

  // ------------------------------------------------------------
  // priority encoder
  // ------------------------------------------------------------
  logic                  rx_data_pend;

  // fifo mode follows the trigger, otherwise any held character
  assign rx_data_pend = fifo_enable ? rx_at_trigger : !rx_fifo_empty;

  always_comb begin
    if (line_pend && interrupt_mask[`UICFS_MASK_LINE]) begin
      src = uicfs_pkg::uicfs_src_line;
    end else if (timeout_pend && interrupt_mask[`UICFS_MASK_RX]) begin
      src = uicfs_pkg::uicfs_src_timeout;
    end else if (rx_data_pend && interrupt_mask[`UICFS_MASK_RX]) begin
      src = uicfs_pkg::uicfs_src_rxdata;
    end else if (tx_pend && interrupt_mask[`UICFS_MASK_TX]) begin
      src = uicfs_pkg::uicfs_src_transmit_ready_interrupt;
    end else if (modem_pend && interrupt_mask[`UICFS_MASK_MODEM]) begin
      src = uicfs_pkg::uicfs_src_modem;
    end else if (xoff_pend && interrupt_mask[`UICFS_MASK_XOFF]) begin
      src = uicfs_pkg::uicfs_src_xoff;
    end else if ((cts_pend && interrupt_mask[`UICFS_MASK_CTS]) ||
                 (rts_pend && interrupt_mask[`UICFS_MASK_RTS])) begin
      src = uicfs_pkg::uicfs_src_flow;
    end else begin
      src = uicfs_pkg::uicfs_src_none;
    end
  end

  function automatic logic [5:0] uicfs_code(input uicfs_pkg::uicfs_src_t s);
    case (s)
      uicfs_pkg::uicfs_src_line:    uicfs_code = `UICFS_ID_LINE;
      uicfs_pkg::uicfs_src_timeout: uicfs_code = `UICFS_ID_TIMEOUT;
      uicfs_pkg::uicfs_src_rxdata:  uicfs_code = `UICFS_ID_RXDATA;
      uicfs_pkg::uicfs_src_transmit_ready_interrupt:   uicfs_code = `UICFS_ID_TRANSMIT_READY_INTERRUPT;
      uicfs_pkg::uicfs_src_modem:   uicfs_code = `UICFS_ID_MODEM;
      uicfs_pkg::uicfs_src_xoff:    uicfs_code = `UICFS_ID_XOFF;
      uicfs_pkg::uicfs_src_flow:    uicfs_code = `UICFS_ID_FLOW;
      default:                      uicfs_code = `UICFS_ID_NONE;
    endcase
  endfunction

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= src != uicfs_pkg::uicfs_src_none;
    end
  end

  // ------------------------------------------------------------
  // avalon slave
  // ------------------------------------------------------------
  logic [7:0] line_status;

  // polled mode needs nothing extra: status stays readable regardless of mask
  assign line_status = {rx_fifo_any_error, tx_all_empty, tx_holding_empty,
                        rx_head_status, !rx_fifo_empty};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_state   <= uicfs_pkg::uicfs_bus_idle;
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else begin
      case (bus_state)
        uicfs_pkg::uicfs_bus_idle: begin
          waitrequest <= 1'b1;
          if (read | write) begin
            bus_state   <= uicfs_pkg::uicfs_bus_answer;
            waitrequest <= 1'b0;
            readdata    <= 32'h0;
            if (read) begin
              case (address)
                `UICFS_OFS_MASK:   readdata[7:0] <= interrupt_mask;
                `UICFS_OFS_IDENT:  readdata[7:0] <= {{2{fifo_enable}}, uicfs_code(src)};
                `UICFS_OFS_LSTAT:  readdata[7:0] <= line_status;
                `UICFS_OFS_CTRL:   readdata[7:0] <= fifo_control_bits;
                default:           readdata[7:0] <= 8'h00;
              endcase
            end
          end
        end
        uicfs_pkg::uicfs_bus_answer: begin
          bus_state   <= uicfs_pkg::uicfs_bus_idle;
          waitrequest <= 1'b1;
        end
        default: begin
          bus_state   <= uicfs_pkg::uicfs_bus_idle;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_irq_follows: assert property (@(posedge clock) disable iff (!rstn)
    (src != uicfs_pkg::uicfs_src_none) |=> irq)
    else $error("irq not raised for pending source");
  a_line_first: assert property (@(posedge clock) disable iff (!rstn)
    (line_pend && interrupt_mask[2]) |-> src == uicfs_pkg::uicfs_src_line)
    else $error("line status not top priority");
  a_ident_fifo: assert property (@(posedge clock) disable iff (!rstn)
    (bus_take && read && address == `UICFS_OFS_IDENT) |=> readdata[7:6] == {2{fifo_enable}})
    else $error("fifo bits wrong in identification");
  a_none_code: assert property (@(posedge clock) disable iff (!rstn)
    (ident_rd && src == uicfs_pkg::uicfs_src_none) |=> readdata[5:0] == 6'h01)
    else $error("idle code wrong");
  a_tx_clear: assert property (@(posedge clock) disable iff (!rstn)
    (tx_holding_write && !tx_enable_rise) |=> !tx_pend)
    else $error("tx ready not cleared");
  a_line_set: assert property (@(posedge clock) disable iff (!rstn)
    (rx_char_stored && rx_char_error) |=> line_pend)
    else $error("line status not set");
  a_flow_hold: assert property (@(posedge clock) disable iff (!rstn)
    (cts_pend && !modem_status_read) |=> cts_pend)
    else $error("flow interrupt dropped early");
  a_fifo_gate: assert property (@(posedge clock) disable iff (!rstn)
    (bus_take && write && address == `UICFS_OFS_FIFOCTL && !writedata[0])
    |=> fifo_control_bits == 8'h00)
    else $error("fifo control written without enable");
  a_bus_answer: assert property (@(posedge clock) disable iff (!rstn)
    bus_take |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");
  a_tx_event: assert property (@(posedge clock) disable iff (!rstn)
    (tx_event_rise && !tx_holding_write) |=> tx_pend)
    else $error("tx ready not raised on event");
  a_tx_enable: assert property (@(posedge clock) disable iff (!rstn)
    tx_enable_rise |=> tx_pend)
    else $error("tx ready not raised on enable");
  a_timeout_set: assert property (@(posedge clock) disable iff (!rstn)
    (rx_timeout_expired && !rx_fifo_empty) |=> timeout_pend)
    else $error("time-out not raised");
  a_timeout_clear: assert property (@(posedge clock) disable iff (!rstn)
    (rx_holding_read && !rx_timeout_expired) |=> !timeout_pend)
    else $error("time-out not cleared");
  a_line_clear: assert property (@(posedge clock) disable iff (!rstn)
    (lstat_rd && !rx_char_stored) |=> !line_pend)
    else $error("line status not cleared");
  a_xoff_set: assert property (@(posedge clock) disable iff (!rstn)
    (xoff_received || special_received) |=> xoff_pend)
    else $error("xoff not raised");
  a_xoff_clear: assert property (@(posedge clock) disable iff (!rstn)
    (xon_received && !xoff_received && !special_received) |=> !xoff_pend)
    else $error("xoff not cleared by xon");
  a_cts_set: assert property (@(posedge clock) disable iff (!rstn)
    (auto_cts && cts_sync[1] && !cts_prev) |=> cts_pend)
    else $error("cts change not raised");
  a_rts_set: assert property (@(posedge clock) disable iff (!rstn)
    (auto_rts && rts_sync[1] && !rts_prev) |=> rts_pend)
    else $error("rts change not raised");
  a_rx_fifo: assert property (@(posedge clock) disable iff (!rstn)
    (fifo_enable && rx_at_trigger && interrupt_mask[`UICFS_MASK_RX])
    |-> src != uicfs_pkg::uicfs_src_none)
    else $error("rx trigger not pending");
  a_rx_plain: assert property (@(posedge clock) disable iff (!rstn)
    (!fifo_enable && !rx_fifo_empty && interrupt_mask[`UICFS_MASK_RX])
    |-> src != uicfs_pkg::uicfs_src_none)
    else $error("held character not pending");
  a_modem_src: assert property (@(posedge clock) disable iff (!rstn)
    ((|modem_deltas) && interrupt_mask[`UICFS_MASK_MODEM])
    |-> src != uicfs_pkg::uicfs_src_none)
    else $error("modem delta not pending");
  a_irq_idle: assert property (@(posedge clock) disable iff (!rstn)
    (src == uicfs_pkg::uicfs_src_none) |=> !irq)
    else $error("irq raised with nothing pending");
  a_mask_guard: assert property (@(posedge clock) disable iff (!rstn)
    (bus_take && write && address == `UICFS_OFS_MASK && !enhanced_enable)
    |=> $stable(interrupt_mask[7:4]))
    else $error("upper mask written without enhanced enable");
  a_fifo_take: assert property (@(posedge clock) disable iff (!rstn)
    (bus_take && write && address == `UICFS_OFS_FIFOCTL && writedata[0])
    |=> fifo_enable && fifo_control_bits == $past(writedata[7:0]))
    else $error("fifo control not taken");
  c_line_irq: cover property (@(posedge clock) disable iff (!rstn) src == uicfs_pkg::uicfs_src_line);
  c_tx_irq: cover property (@(posedge clock) disable iff (!rstn) src == uicfs_pkg::uicfs_src_transmit_ready_interrupt);
  c_flow_irq: cover property (@(posedge clock) disable iff (!rstn) src == uicfs_pkg::uicfs_src_flow);
  c_tout_irq: cover property (@(posedge clock) disable iff (!rstn) src == uicfs_pkg::uicfs_src_timeout);
  c_xoff_irq: cover property (@(posedge clock) disable iff (!rstn) src == uicfs_pkg::uicfs_src_xoff);

endmodule
`default_nettype wire

// *** uicfs_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// host side of the register bus
// ---------------------------------------------
module uicfs_host (
  input  wire logic        clock,
  output var  logic [7:0]  address,
  output var  logic        read,
  output var  logic        write,
  output var  logic [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  initial begin
    address <= 8'hFF;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= 32'hFFFFFFFF;
  end
  // released lines show the inverse, so a stale address never looks valid
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
    int n;
    @(posedge clock);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    q = readdata;
    ok = (waitrequest === 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask
endmodule
`default_nettype wire

// *** test_uicfs_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uicfs_cfg.svh"
module test_uicfs_top;
  logic        clock, rstn, read, write, waitrequest, irq, fifo_enable, ok;
  logic [7:0]  address, fifo_control_bits;
  logic [31:0] writedata, readdata, q;
  logic [3:0]  rx_head_status, modem_deltas;
  logic        rx_char_stored, rx_char_error, rx_fifo_any_error, rx_fifo_empty;
  logic        rx_at_trigger, rx_timeout_expired, rx_holding_read, tx_holding_empty;
  logic        tx_below_trigger, tx_fifo_empty, tx_all_empty, tx_holding_write;
  logic        rs485_mode, modem_status_read, enhanced_enable, auto_cts, auto_rts;
  logic        cts_pin, rts_pin, xoff_received, xon_received, special_received;
  int          fail_count, n_tests;
  uicfs_top i_uicfs_top (.clock, .rstn, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .rx_char_stored, .rx_char_error, .rx_head_status, .rx_fifo_any_error,
    .rx_fifo_empty, .rx_at_trigger, .rx_timeout_expired, .rx_holding_read,
    .tx_holding_empty, .tx_below_trigger, .tx_fifo_empty, .tx_all_empty,
    .tx_holding_write, .rs485_mode, .modem_deltas, .modem_status_read, .enhanced_enable,
    .auto_cts, .auto_rts, .cts_pin, .rts_pin, .xoff_received, .xon_received,
    .special_received, .irq, .fifo_enable, .fifo_control_bits);
  uicfs_host i_uicfs_host (.clock, .address, .read, .write, .writedata, .readdata,
    .waitrequest);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ---------------------------------------------
  // checks and bus tasks
  // ---------------------------------------------
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_uicfs_host.access(1'b0, a, 32'h0, q, ok);
    chk({31'h0, ok}, 32'h1);
    if (!ok) conclude();
    chk(q, {24'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_uicfs_host.access(1'b1, a, {24'h0, d}, q, ok);
    if (!ok) begin
      fail_count++;
      conclude();
    end
  endtask
  // bounded wait: irq trails its source by a cycle
  task automatic wirq(input logic e);
    for (int n = 0; n < 16 && irq !== e; n++) @(posedge clock);
    chk({31'h0, irq}, {31'h0, e});
    if (irq !== e) conclude();
  endtask
  initial begin
    #400000;
    fail_count++;
    conclude();
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    fail_count = 0;
    n_tests = 0;
    rstn = 1'b0;
    {rx_char_stored, rx_char_error, rx_fifo_any_error, rx_at_trigger} = 4'h0;
    {rx_timeout_expired, rx_holding_read, tx_holding_empty, tx_below_trigger} = 4'h0;
    {tx_fifo_empty, tx_all_empty, tx_holding_write, rs485_mode} = 4'h0;
    {modem_status_read, enhanced_enable, auto_cts, auto_rts} = 4'h0;
    {cts_pin, rts_pin, xoff_received, xon_received, special_received} = 5'h00;
    rx_fifo_empty = 1'b1;
    rx_head_status = 4'h0;
    modem_deltas = 4'h0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    chk({31'h0, irq}, 32'h0);
    rd(`UICFS_OFS_IDENT, 8'h01);
    wr(`UICFS_OFS_MASK, 8'hFF);
    rd(`UICFS_OFS_MASK, 8'h0F);
    wr(`UICFS_OFS_FIFOCTL, 8'hF0);
    rd(`UICFS_OFS_CTRL, 8'h00);
    wr(`UICFS_OFS_FIFOCTL, 8'hC1);
    rd(`UICFS_OFS_CTRL, 8'hC1);
    chk({31'h0, fifo_enable}, 32'h1);
    rd(`UICFS_OFS_IDENT, 8'hC1);
    $display("test config done");
    // polled mode: sources present, every mask bit off
    wr(`UICFS_OFS_MASK, 8'h00);
    rx_fifo_empty <= 1'b0;
    rx_head_status <= 4'hA;
    rx_fifo_any_error <= 1'b1;
    tx_holding_empty <= 1'b1;
    tx_all_empty <= 1'b1;
    rx_at_trigger <= 1'b1;
    modem_deltas <= 4'h1;
    repeat (4) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    rd(`UICFS_OFS_LSTAT, 8'hF5);
    $display("test polled done");
    wr(`UICFS_OFS_MASK, 8'h0D);
    rx_char_error <= 1'b1;
    rx_char_stored <= 1'b1;
    @(posedge clock);
    rx_char_stored <= 1'b0;
    rx_char_error <= 1'b0;
    wirq(1'b1);
    rd(`UICFS_OFS_IDENT, 8'hC0 | {2'b00, `UICFS_ID_LINE});
    rd(`UICFS_OFS_LSTAT, 8'hF5);
    rd(`UICFS_OFS_IDENT, 8'hC0 | {2'b00, `UICFS_ID_RXDATA});
    rx_at_trigger <= 1'b0;
    rd(`UICFS_OFS_IDENT, 8'hC0 | {2'b00, `UICFS_ID_MODEM});
    modem_deltas <= 4'h0;
    modem_status_read <= 1'b1;
    @(posedge clock);
    modem_status_read <= 1'b0;
    wirq(1'b0);
    rx_timeout_expired <= 1'b1;
    @(posedge clock);
    rx_timeout_expired <= 1'b0;
    wirq(1'b1);
    rd(`UICFS_OFS_IDENT, 8'hC0 | {2'b00, `UICFS_ID_TIMEOUT});
    rx_holding_read <= 1'b1;
    @(posedge clock);
    rx_holding_read <= 1'b0;
    wirq(1'b0);
    $display("test priority done");
    wr(`UICFS_OFS_MASK, 8'h02);
    wirq(1'b1);
    rd(`UICFS_OFS_IDENT, 8'hC0 | {2'b00, `UICFS_ID_TRANSMIT_READY_INTERRUPT});
    wirq(1'b0);
    // fifo mode: the event is the trigger or fifo empty, not the holding register
    tx_below_trigger <= 1'b1;
    wirq(1'b1);
    tx_holding_write <= 1'b1;
    tx_below_trigger <= 1'b0;
    @(posedge clock);
    tx_holding_write <= 1'b0;
    wirq(1'b0);
    tx_fifo_empty <= 1'b1;
    wirq(1'b1);
    rd(`UICFS_OFS_IDENT, 8'hC0 | {2'b00, `UICFS_ID_TRANSMIT_READY_INTERRUPT});
    wirq(1'b0);
    rs485_mode <= 1'b1;
    tx_all_empty <= 1'b0;
    @(posedge clock);
    tx_all_empty <= 1'b1;
    wirq(1'b1);
    tx_holding_write <= 1'b1;
    @(posedge clock);
    tx_holding_write <= 1'b0;
    rs485_mode <= 1'b0;
    wirq(1'b0);
    $display("test transmit done");
    // fifos off: rx data follows the holding register
    wr(`UICFS_OFS_MASK, 8'h01);
    wr(`UICFS_OFS_FIFOCTL, 8'h00);
    wirq(1'b1);
    rd(`UICFS_OFS_IDENT, {2'b00, `UICFS_ID_RXDATA});
    rx_fifo_empty <= 1'b1;
    wirq(1'b0);
    rd(`UICFS_OFS_LSTAT, 8'hF4);
    $display("test non fifo done");
    enhanced_enable <= 1'b1;
    wr(`UICFS_OFS_MASK, 8'hE0);
    rd(`UICFS_OFS_MASK, 8'hE0);
    xoff_received <= 1'b1;
    @(posedge clock);
    xoff_received <= 1'b0;
    wirq(1'b1);
    rd(`UICFS_OFS_IDENT, {2'b00, `UICFS_ID_XOFF});
    wirq(1'b0);
    special_received <= 1'b1;
    @(posedge clock);
    special_received <= 1'b0;
    wirq(1'b1);
    rx_char_stored <= 1'b1;
    @(posedge clock);
    rx_char_stored <= 1'b0;
    wirq(1'b0);
    xoff_received <= 1'b1;
    @(posedge clock);
    xoff_received <= 1'b0;
    wirq(1'b1);
    xon_received <= 1'b1;
    @(posedge clock);
    xon_received <= 1'b0;
    wirq(1'b0);
    auto_cts <= 1'b1;
    auto_rts <= 1'b1;
    cts_pin <= 1'b1;
    wirq(1'b1);
    rd(`UICFS_OFS_IDENT, {2'b00, `UICFS_ID_FLOW});
    rd(`UICFS_OFS_IDENT, {2'b00, `UICFS_ID_FLOW});
    modem_status_read <= 1'b1;
    @(posedge clock);
    modem_status_read <= 1'b0;
    wirq(1'b0);
    rts_pin <= 1'b1;
    wirq(1'b1);
    modem_status_read <= 1'b1;
    @(posedge clock);
    modem_status_read <= 1'b0;
    wirq(1'b0);
    $display("test enhanced done");
    conclude();
  end
endmodule
`default_nettype wire
